//--- dv/host_byte_engine.sv
// Host side byte engine: command, data and read strobes, plus result.
// Assumes the block samples strobes on the rising clk_in edge.
`timescale 1ns/1ps
module host_byte_engine (
   // Clock and read-back
   input  wire        clk_in,
   input  wire [7:0]  rd_data_in,
   // Strobes and byte lane
   output reg         cmd_wr_out,
   output reg         data_wr_out,
   output reg         data_rd_out,
   output reg  [7:0]  data_out,
   // Converter result stand-in
   output reg  [15:0] result_out
);
   // Quiet lines at time zero
   initial begin
      {cmd_wr_out, data_wr_out, data_rd_out} = 3'h0;
      data_out = 8'h5a;
      result_out = 16'h0000;
   end
   // One strobe for one cycle; lane inverted once released
   task send(input [2:0] kind, input [7:0] v);
      begin
         @(posedge clk_in);
         {cmd_wr_out, data_wr_out, data_rd_out} <= kind;
         data_out <= v;
         @(posedge clk_in);
         {cmd_wr_out, data_wr_out, data_rd_out} <= 3'h0;
         data_out <= ~v;
         #1;
      end
   endtask
   // Command byte
   task cmd(input [7:0] c);
      send(3'h4, c);
   endtask
   // Data byte, sent as given; callers may set reserved bits
   task put(input [7:0] v);
      send(3'h2, v);
   endtask
   // Read byte, taken once the strobe edge has landed
   task get(output [7:0] v);
      begin
         send(3'h1, 8'h00);
         v = rd_data_in;
      end
   endtask
   // Result changes just after an edge, never at evaluation
   task set_result(input [15:0] r);
      begin
         @(posedge clk_in);
         result_out <= r;
         #1;
      end
   endtask
endmodule

//--- dv/prox_ctrl_assertions.sv
// Port checker for the proximity measurement control block.
// Assumes ce_in low only while idle, and bench step and pulse counts.
`timescale 1ns/1ps
module prox_ctrl_checker #(
   parameter STEP_CYCLES  = 4,
   parameter PULSE_CYCLES = 4
) (
   // Clock, reset, enable
   input wire        clk_in,
   input wire        srst_in,
   input wire        ce_in,
   // Byte port
   input wire        cmd_wr_in,
   input wire        data_wr_in,
   input wire        data_rd_in,
   input wire [7:0]  data_in,
   input wire [7:0]  rd_data_out,
   // Result and pins
   input wire [15:0] prox_result_in,
   input wire        osc_enable_out,
   input wire        led_driver_pin_out,
   input wire        led_current_reduce_out,
   input wire        integrate_out,
   input wire        prox_irq_out
);
   reg [31:0] integ_len;  // Cycles of current integration
   reg [31:0] led_len;    // Cycles of current LED high
   // Run lengths of integration and LED high time
   always @(posedge clk_in) begin
      integ_len <= (srst_in || !integrate_out) ? 32'h0 : integ_len + 32'h1;
      led_len   <= (srst_in || !led_driver_pin_out) ? 32'h0 : led_len + 32'h1;
   end
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (srst_in);
   reset_clears_outputs_a: assert property (disable iff (1'b0) srst_in |=> rd_data_out == 8'h00
      && !prox_irq_out && !osc_enable_out && !integrate_out && !led_driver_pin_out)
      else $error("outputs not cleared by reset");
   integ_whole_steps_a: assert property ($fell(integrate_out) && !$past(srst_in)
      && !$past(data_wr_in) && !$past(data_wr_in, 2)
      |-> integ_len != 0 && integ_len % STEP_CYCLES == 0)
      else $error("integration not a whole number of steps");
   irq_after_eval_a: assert property ($rose(prox_irq_out)
      |-> $past(integrate_out, 2) && !$past(integrate_out))
      else $error("interrupt rose outside evaluation");
   irq_clear_cmd_a: assert property (cmd_wr_in && data_in == 8'he7
      && !$past(integrate_out) |=> !prox_irq_out)
      else $error("interrupt not cleared by command");
   irq_fall_cause_a: assert property ($fell(prox_irq_out) |-> $past(srst_in)
      || $past(cmd_wr_in) && ($past(data_in) & 8'hfd) == 8'he5)
      else $error("interrupt fell without clear");
   osc_fall_cause_a: assert property ($fell(osc_enable_out) |-> $past(srst_in)
      || $past(data_wr_in) || prox_irq_out)
      else $error("oscillator stopped without cause");
   osc_stops_timers_a: assert property (!osc_enable_out && !$past(osc_enable_out)
      && !$past(osc_enable_out, 2) |-> !integrate_out && !led_driver_pin_out)
      else $error("timers run without oscillator");
   led_integ_gap_a: assert property (led_driver_pin_out |-> !$past(integrate_out))
      else $error("LED pulse during integration");
   led_half_period_a: assert property (led_driver_pin_out |-> led_len < PULSE_CYCLES / 2)
      else $error("LED pulse too long");
   read_data_holds_a: assert property (!data_rd_in && !srst_in |=> $stable(rd_data_out))
      else $error("read data changed without read");
endmodule
bind proximity_measure_control prox_ctrl_checker #(.STEP_CYCLES(STEP_CYCLES),
   .PULSE_CYCLES(PULSE_CYCLES)) chk_i (.clk_in(clk_in),
   .srst_in(srst_in), .ce_in(ce_in), .cmd_wr_in(cmd_wr_in), .data_wr_in(data_wr_in),
   .data_rd_in(data_rd_in), .data_in(data_in), .rd_data_out(rd_data_out),
   .prox_result_in(prox_result_in), .osc_enable_out(osc_enable_out),
   .led_driver_pin_out(led_driver_pin_out), .led_current_reduce_out(led_current_reduce_out),
   .integrate_out(integrate_out), .prox_irq_out(prox_irq_out));

//--- dv/tb_top.sv
// Testbench for the proximity measurement control block.
// Assumes short step and pulse counts of four cycles each.
`timescale 1ns/1ps
module tb_top;
   reg         clk_in, srst_in, ce_in;           // Clock, reset, enable
   wire        cmd_wr, data_wr, data_rd;         // Host strobes
   wire [7:0]  data_b, rd_data;                  // Byte lanes
   wire [15:0] result;                           // Converter result
   wire        osc_en, led, led_low, integ, irq; // Block outputs
   integer     err_count, compares, run, last_hi, last_lo, evals, pulses, last_pulses, i;
   reg         prev_i, prev_l;                   // Last sampled levels
   reg  [7:0]  v;                                // Read byte
   proximity_measure_control #(.STEP_CYCLES(4), .PULSE_CYCLES(4))
      proximity_measure_control_i (.clk_in(clk_in), .srst_in(srst_in), .ce_in(ce_in),
      .cmd_wr_in(cmd_wr), .data_wr_in(data_wr), .data_rd_in(data_rd), .data_in(data_b),
      .rd_data_out(rd_data), .prox_result_in(result), .osc_enable_out(osc_en),
      .led_driver_pin_out(led), .led_current_reduce_out(led_low), .integrate_out(integ),
      .prox_irq_out(irq));
   host_byte_engine host_byte_engine_i (.clk_in(clk_in), .rd_data_in(rd_data),
      .cmd_wr_out(cmd_wr), .data_wr_out(data_wr), .data_rd_out(data_rd),
      .data_out(data_b), .result_out(result));
   // Free running clock
   initial begin
      clk_in = 1'b0;
      forever #25 clk_in = ~clk_in;
   end
   // Integration length, gap length, evaluations and LED pulses
   always @(posedge clk_in) begin
      prev_i <= integ;
      prev_l <= led;
      run <= (integ != prev_i) ? 1 : run + 1;
      if (integ && !prev_i) begin
         last_lo <= run;
         last_pulses <= pulses;
         pulses <= 0;
      end else if (led && !prev_l)
         pulses <= pulses + 1;
      if (!integ && prev_i) begin
         last_hi <= run;
         evals <= evals + 1;
      end
   end
   // Compare and count
   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      begin
         compares = compares + 1;
         if (seen !== exp) begin
            err_count = err_count + 1;
            $display("BAD %s expected %h seen %h", name, exp, seen);
         end
      end
   endtask
   // Counts and verdict
   task give_verdict;
      begin
         $display("Counts: %0d compares, %0d mismatches", compares, err_count);
         if (err_count == 0 && compares > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask
   // Register write, repeated-byte type
   task wr(input [7:0] a, input [7:0] d);
      begin
         host_byte_engine_i.cmd(8'h80 | a);
         host_byte_engine_i.put(d);
      end
   endtask
   // Register read and compare
   task rdc(input string name, input [7:0] a, input [7:0] exp);
      begin
         host_byte_engine_i.cmd(8'h80 | a);
         host_byte_engine_i.get(v);
         check(name, v, exp);
      end
   endtask
   // Bounded wait for n evaluations
   task wait_evals(input integer n);
      integer start, k;
      begin
         start = evals;
         k = 0;
         while (evals < start + n && k < 4000) begin
            @(posedge clk_in);
            #1;
            k = k + 1;
         end
         if (k >= 4000) begin
            err_count = err_count + 1;
            $display("BAD eval_wait expected done seen timeout");
            give_verdict;
         end
      end
   endtask
   // Main sequence
   initial begin
      {srst_in, ce_in, prev_i, prev_l} = 4'b1100;
      {err_count, compares, run, last_hi, last_lo, evals, pulses, last_pulses} = 0;
      repeat (20) @(posedge clk_in);
      srst_in <= 1'b0;
      rdc("enable", 8'h00, 8'h00);
      rdc("integ_time", 8'h02, 8'hff);
      rdc("wait_time", 8'h03, 8'hff);
      rdc("status", 8'h13, 8'h00);
      rdc("unmapped", 8'h01, 8'h00);
      $display("test reset_values done");
      wr(8'h0c, 8'hff);
      rdc("filter", 8'h0c, 8'hf0);
      wr(8'h0d, 8'h03);
      check("led_reduce", led_low, 1);
      rdc("config", 8'h0d, 8'h03);
      wr(8'h0d, 8'h00);
      check("led_reduce", led_low, 0);
      host_byte_engine_i.cmd(8'ha8);
      for (i = 0; i < 4; i = i + 1)
         host_byte_engine_i.put(8'h11 * (i + 1));
      host_byte_engine_i.cmd(8'ha8);
      for (i = 0; i < 4; i = i + 1) begin
         host_byte_engine_i.get(v);
         check("threshold", v, 8'h11 * (i + 1));
      end
      host_byte_engine_i.cmd(8'h88);
      host_byte_engine_i.cmd(8'h0c);
      host_byte_engine_i.get(v);
      check("repeat_byte", v, 8'h11);
      $display("test registers done");
      host_byte_engine_i.set_result(16'h3000);
      wr(8'h02, 8'hfe);
      wr(8'h03, 8'hfe);
      wr(8'h0e, 8'h08);
      wr(8'h0c, 8'h00);
      wr(8'h00, 8'h2d);
      wait_evals(2);
      check("integ_len", last_hi, 8);
      check("gap_wait", last_lo, 42);
      check("pulses", last_pulses, 8);
      check("irq_every", irq, 1);
      wr(8'h0d, 8'h02);
      wait_evals(2);
      check("gap_long", last_lo, 130);
      wr(8'h00, 8'h25);
      wr(8'h0d, 8'h00);
      wait_evals(2);
      check("gap_nowait", last_lo, 34);
      rdc("status", 8'h13, 8'h22);
      wr(8'h00, 8'h21);
      host_byte_engine_i.cmd(8'he7);
      check("irq_clear", irq, 0);
      host_byte_engine_i.get(v);
      check("pointer_kept", v, 8'h21);
      i = evals;
      repeat (60) @(posedge clk_in);
      check("prox_off", evals, i);
      $display("test cycle done");
      wr(8'h00, 8'h05);
      wait_evals(2);
      check("irq_masked", irq, 0);
      host_byte_engine_i.set_result(16'h4433);
      wr(8'h0c, 8'h20);
      wr(8'h00, 8'h25);
      wait_evals(3);
      check("irq_edge", irq, 0);
      host_byte_engine_i.set_result(16'h4434);
      wait_evals(1);
      check("irq_one", irq, 0);
      wait_evals(1);
      check("irq_two", irq, 1);
      $display("test persistence done");
      host_byte_engine_i.cmd(8'he5);
      check("irq_clear_a", irq, 0);
      host_byte_engine_i.set_result(16'h2210);
      wr(8'h0c, 8'h10);
      wr(8'h00, 8'h65);
      wait_evals(1);
      check("sleep_irq", irq, 1);
      check("sleep_osc", osc_en, 0);
      rdc("enable", 8'h00, 8'h64);
      rdc("status", 8'h13, 8'h20);
      i = evals;
      repeat (60) @(posedge clk_in);
      check("asleep", evals, i);
      @(posedge clk_in);
      ce_in <= 1'b0;
      wr(8'h00, 8'h25);
      @(posedge clk_in);
      ce_in <= 1'b1;
      rdc("frozen", 8'h00, 8'h64);
      $display("test sleep done");
      give_verdict;
   end
endmodule

//--- hdl/prox_ctrl_defines.vh
// Register map, field positions, reset values and timing counts
// for the proximity measurement control block.
// Assumes a 20 MHz system clock; all times are derived from its period.
`ifndef PROX_CTRL_DEFINES_VH
`define PROX_CTRL_DEFINES_VH

// Register offsets
`define ADDR_FUNCTION_ENABLE   5'h00
`define ADDR_INTEGRATION_TIME  5'h02
`define ADDR_WAIT_DURATION     5'h03
`define ADDR_LOW_THR_LO        5'h08
`define ADDR_LOW_THR_HI        5'h09
`define ADDR_HIGH_THR_LO       5'h0a
`define ADDR_HIGH_THR_HI       5'h0b
`define ADDR_INTERRUPT_FILTER  5'h0c
`define ADDR_WAIT_DRIVE_CONFIG 5'h0d
`define ADDR_LED_PULSE_COUNT   5'h0e
`define ADDR_STATUS            5'h13

// Reset values
`define RST_FUNCTION_ENABLE    8'h00
`define RST_INTEGRATION_TIME   8'hff
`define RST_WAIT_DURATION      8'hff
`define RST_ZERO               8'h00

// Function enable fields
`define BIT_POWER_UP           0
`define BIT_PROX_ENABLE        2
`define BIT_WAIT_ENABLE        3
`define BIT_PROX_IRQ_MASK      5
`define BIT_SLEEP_AFTER_IRQ    6
`define MASK_FUNCTION_ENABLE   8'h6d

// Configuration fields
`define BIT_LED_CURRENT_REDUCE 0
`define BIT_WAIT_STRETCH       1
`define MASK_WAIT_DRIVE_CONFIG 8'h03

// Interrupt filter field
`define FILTER_MSB             7
`define FILTER_LSB             4
`define MASK_INTERRUPT_FILTER  8'hf0

// Status fields
`define BIT_PROX_IRQ_FLAG      5
`define BIT_PROX_RESULT_READY  1

// Command byte fields
`define CMD_SELECT_BIT         7
`define CMD_TYPE_MSB           6
`define CMD_TYPE_LSB           5
`define CMD_TYPE_AUTO_INC      2'b01
`define CMD_TYPE_SPECIAL       2'b11
`define CMD_FUNC_IRQ_CLEAR_A   5'h05
`define CMD_FUNC_IRQ_CLEAR_B   5'h07

// Timing
`define CLK_PERIOD_NS          50
`define STEP_TIME_NS           2730000
`define STEP_CYCLES            ((`STEP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PULSE_PERIOD_NS        16000
`define PULSE_CYCLES           (`PULSE_PERIOD_NS / `CLK_PERIOD_NS)
`define WAIT_STRETCH_FACTOR    12
`define STEP_COUNT_SPAN        9'h100

`endif

//--- hdl/proximity_measure_control.v
// Proximity measurement control: register file behind the serial
// command/data byte port, cycle sequencer, LED pulser and interrupt.
// Assumes a serial bus engine outside delivers whole command and data
// bytes as one-cycle strobes synchronous to clk_in.
// Timers count clk_in cycles; ce_in low freezes all state.
// The result input is sampled only in the evaluation state.
// Interrupt output is a level, active high.
// Register writes land on the strobe edge.
//
// Contract
// - Power bit runs timers; clear stops them
// - Proximity enable bit turns measurement on/off
// - Wait enable bit gates inter-cycle wait timer
// - Interrupts only while mask bit set
// - Sleep after interrupt at cycle end
// - Integration time in 2.73 ms steps
// - Wait count is two's complement steps
// - Wait stretch makes steps twelve times longer
// - Interrupt when result outside threshold window; with filter zero the code fires on every evaluation
// - Thresholds are 16-bit from byte pairs
// - Filter N needs N consecutive out-of-window
// - Drive-level bit reduces LED current
// - Emit pulse-count pulses at 62.5 kHz
// - Special command clears pending interrupt
// - Status bit 5 shows interrupt asserted
// - Status bit 1 set after integration
`timescale 1ns/1ps
`include "prox_ctrl_defines.vh"

module proximity_measure_control #(
   parameter STEP_CYCLES  = `STEP_CYCLES,   // Cycles per 2.73 ms step
   parameter PULSE_CYCLES = `PULSE_CYCLES,  // Cycles per LED pulse period
   parameter STRETCH      = `WAIT_STRETCH_FACTOR
) (
   // Clock, reset, enable
   input  wire        clk_in,
   input  wire        srst_in,
   input  wire        ce_in,
   // Serial byte port
   input  wire        cmd_wr_in,
   input  wire        data_wr_in,
   input  wire        data_rd_in,
   input  wire [7:0]  data_in,
   output reg  [7:0]  rd_data_out,
   // Converter result
   input  wire [15:0] prox_result_in,
   // Analog and pin side
   output wire        osc_enable_out,
   output reg         led_driver_pin_out,
   output wire        led_current_reduce_out,
   output wire        integrate_out,
   output wire        prox_irq_out
);

   // Sequencer states
   localparam [4:0] ST_IDLE  = 5'b00001;  // Powered down or disabled
   localparam [4:0] ST_PULSE = 5'b00010;  // LED pulsing
   localparam [4:0] ST_INTEG = 5'b00100;  // Integration
   localparam [4:0] ST_EVAL  = 5'b01000;  // Threshold and filter
   localparam [4:0] ST_WAIT  = 5'b10000;  // Wait between cycles

   // Registers
   reg  [7:0]  function_enable;
   reg  [7:0]  integration_time;
   reg  [7:0]  wait_duration;
   reg  [7:0]  low_threshold_lo_byte;
   reg  [7:0]  low_threshold_hi_byte;
   reg  [7:0]  high_threshold_lo_byte;
   reg  [7:0]  high_threshold_hi_byte;
   reg  [7:0]  interrupt_filter;
   reg  [7:0]  wait_and_drive_config;
   reg  [7:0]  led_pulse_count;
   // Port state and status flags
   reg  [4:0]  reg_addr;             // Selected register
   reg         auto_inc;             // Auto-increment access mode
   reg         prox_irq_flag;        // Pending interrupt
   reg         prox_result_ready;    // Integration completed

   // Sequencer
   reg  [4:0]  state;
   reg  [31:0] tick_cnt;             // Cycles within a step or pulse
   reg  [8:0]  step_cnt;             // Steps or pulses done
   reg  [3:0]  stretch_cnt;          // Sub-steps of a stretched wait step
   reg  [3:0]  out_run;              // Consecutive out-of-window results

   // Decoded fields
   wire        power_up_bit          = function_enable[`BIT_POWER_UP];
   wire        prox_function_enable  = function_enable[`BIT_PROX_ENABLE];
   wire        wait_enable           = function_enable[`BIT_WAIT_ENABLE];
   wire        prox_irq_mask         = function_enable[`BIT_PROX_IRQ_MASK];
   wire        sleep_after_irq       = function_enable[`BIT_SLEEP_AFTER_IRQ];
   wire        wait_stretch          = wait_and_drive_config[`BIT_WAIT_STRETCH];
   wire [3:0]  interrupt_filter_count =
               interrupt_filter[`FILTER_MSB:`FILTER_LSB];
   wire [15:0] low_threshold  = {low_threshold_hi_byte, low_threshold_lo_byte};
   wire [15:0] high_threshold = {high_threshold_hi_byte, high_threshold_lo_byte};

   // Command decode
   // Special commands leave the pointer alone
   wire [1:0]  cmd_type = data_in[`CMD_TYPE_MSB:`CMD_TYPE_LSB];
   wire [4:0]  cmd_func = data_in[4:0];
   wire        cmd_ok   = cmd_wr_in && data_in[`CMD_SELECT_BIT];
   wire        irq_clear = cmd_ok && (cmd_type == `CMD_TYPE_SPECIAL) &&
                           ((cmd_func == `CMD_FUNC_IRQ_CLEAR_A) ||
                            (cmd_func == `CMD_FUNC_IRQ_CLEAR_B));

   // Evaluation
   // Run length saturates at 15, never wraps
   wire        out_of_window = (prox_result_in < low_threshold) ||
                               (prox_result_in > high_threshold);
   wire [3:0]  next_out_run  = out_of_window ?
                               ((out_run == 4'hf) ? 4'hf : out_run + 4'h1) : 4'h0;
   wire        fire = (interrupt_filter_count == 4'h0) ||
                      (out_of_window && next_out_run >= interrupt_filter_count);
   wire        irq_set   = ce_in && (state == ST_EVAL) && fire && prox_irq_mask;
   wire        step_done = (tick_cnt == STEP_CYCLES - 1);
   wire        pulse_done = (tick_cnt == PULSE_CYCLES - 1);
   wire        sleep_now = (state == ST_EVAL) && sleep_after_irq &&
                           (prox_irq_flag || irq_set);
   wire        enable_wr = data_wr_in && (reg_addr == `ADDR_FUNCTION_ENABLE);

   // Register read mux
   // Unmapped addresses read as zero
   function [7:0] read_reg;
      input [4:0] a;
      begin
         case (a)
            `ADDR_FUNCTION_ENABLE:   read_reg = function_enable;
            `ADDR_INTEGRATION_TIME:  read_reg = integration_time;
            `ADDR_WAIT_DURATION:     read_reg = wait_duration;
            `ADDR_LOW_THR_LO:        read_reg = low_threshold_lo_byte;
            `ADDR_LOW_THR_HI:        read_reg = low_threshold_hi_byte;
            `ADDR_HIGH_THR_LO:       read_reg = high_threshold_lo_byte;
            `ADDR_HIGH_THR_HI:       read_reg = high_threshold_hi_byte;
            `ADDR_INTERRUPT_FILTER:  read_reg = interrupt_filter;
            `ADDR_WAIT_DRIVE_CONFIG: read_reg = wait_and_drive_config;
            `ADDR_LED_PULSE_COUNT:   read_reg = led_pulse_count;
            `ADDR_STATUS:            read_reg = {2'b00, prox_irq_flag, 3'b000,
                                                 prox_result_ready, 1'b0};
            default:                 read_reg = 8'h00;
         endcase
      end
   endfunction

   // Outputs
   // Pin mirrors the pending flag until cleared
   assign osc_enable_out         = power_up_bit;
   assign led_current_reduce_out =
          wait_and_drive_config[`BIT_LED_CURRENT_REDUCE];
   assign integrate_out          = (state == ST_INTEG);
   assign prox_irq_out           = prox_irq_flag;

   // Command register, address pointer and read data
   // A non-special command beats a data strobe in the same cycle here
   // Pointer wraps in the five-bit address space
   always @(posedge clk_in) begin
      if (srst_in) begin
         reg_addr    <= 5'h00;
         auto_inc    <= 1'b0;
         rd_data_out <= 8'h00;
      end else if (ce_in) begin
         if (cmd_ok && cmd_type != `CMD_TYPE_SPECIAL) begin
            // Select target register and access mode
            reg_addr <= cmd_func;
            auto_inc <= (cmd_type == `CMD_TYPE_AUTO_INC);
         end else if (data_rd_in) begin
            // Capture byte, step pointer in auto-increment mode
            rd_data_out <= read_reg(reg_addr);
            if (auto_inc)
               reg_addr <= reg_addr + 5'h01;
         end else if (data_wr_in && auto_inc) begin
            reg_addr <= reg_addr + 5'h01;
         end
      end
   end

   // Writable registers; reserved bits are stored as zero
   // Read-back never shows reserved bits
   always @(posedge clk_in) begin
      if (srst_in) begin
         function_enable        <= `RST_FUNCTION_ENABLE;
         integration_time       <= `RST_INTEGRATION_TIME;
         wait_duration          <= `RST_WAIT_DURATION;
         low_threshold_lo_byte  <= `RST_ZERO;
         low_threshold_hi_byte  <= `RST_ZERO;
         high_threshold_lo_byte <= `RST_ZERO;
         high_threshold_hi_byte <= `RST_ZERO;
         interrupt_filter       <= `RST_ZERO;
         wait_and_drive_config  <= `RST_ZERO;
         led_pulse_count        <= `RST_ZERO;
      end else if (ce_in) begin
         if (data_wr_in) begin
            case (reg_addr)
               `ADDR_FUNCTION_ENABLE:
                  function_enable <= data_in & `MASK_FUNCTION_ENABLE;
               `ADDR_INTEGRATION_TIME:  integration_time       <= data_in;
               `ADDR_WAIT_DURATION:     wait_duration          <= data_in;
               `ADDR_LOW_THR_LO:        low_threshold_lo_byte  <= data_in;
               `ADDR_LOW_THR_HI:        low_threshold_hi_byte  <= data_in;
               `ADDR_HIGH_THR_LO:       high_threshold_lo_byte <= data_in;
               `ADDR_HIGH_THR_HI:       high_threshold_hi_byte <= data_in;
               `ADDR_INTERRUPT_FILTER:
                  interrupt_filter <= data_in & `MASK_INTERRUPT_FILTER;
               `ADDR_WAIT_DRIVE_CONFIG:
                  wait_and_drive_config <= data_in & `MASK_WAIT_DRIVE_CONFIG;
               `ADDR_LED_PULSE_COUNT:   led_pulse_count        <= data_in;
               default:                 ;  // Unmapped or read-only
            endcase
         end

         // Sleep after interrupt drops power unless host writes enable now
         if (sleep_now && !enable_wr)
            function_enable[`BIT_POWER_UP] <= 1'b0;
      end
   end

   // Interrupt flag and result-ready flag; set wins over clear
   // A clear on the evaluation edge loses to the set
   // Ready drops only when power is switched off
   always @(posedge clk_in) begin
      if (srst_in) begin
         prox_irq_flag     <= 1'b0;
         prox_result_ready <= 1'b0;
      end else if (ce_in) begin
         if (irq_set)
            prox_irq_flag <= 1'b1;
         else if (irq_clear)
            prox_irq_flag <= 1'b0;

         if (state == ST_INTEG && step_done &&
             step_cnt == `STEP_COUNT_SPAN - {1'b0, integration_time} - 9'h001)
            prox_result_ready <= 1'b1;
         else if (!power_up_bit)
            prox_result_ready <= 1'b0;
      end
   end

   // Measurement cycle sequencer
   // IDLE, PULSE, INTEG, EVAL, WAIT (only with wait bit set), IDLE while enabled
   // A zero pulse count goes straight to INTEG
   // Losing power or enable aborts within one edge
   // Persistence run survives a brief disable
   always @(posedge clk_in) begin
      if (srst_in) begin
         state              <= ST_IDLE;
         tick_cnt           <= 32'd0;
         step_cnt           <= 9'h000;
         stretch_cnt        <= 4'h0;
         out_run            <= 4'h0;
         led_driver_pin_out <= 1'b0;
      end else if (ce_in) begin
         if (!power_up_bit || !prox_function_enable) begin
            // Oscillator stopped or function off: hold idle
            state              <= ST_IDLE;
            tick_cnt           <= 32'd0;
            step_cnt           <= 9'h000;
            stretch_cnt        <= 4'h0;
            led_driver_pin_out <= 1'b0;
         end else begin
            case (state)
               ST_IDLE: begin
                  // Start a new cycle
                  tick_cnt <= 32'd0;
                  step_cnt <= 9'h000;
                  state    <= (led_pulse_count == 8'h00) ? ST_INTEG : ST_PULSE;
               end

               ST_PULSE: begin
                  // High for first half of each 62.5 kHz period
                  // Pin lags the counter one clock
                  led_driver_pin_out <= (tick_cnt < PULSE_CYCLES / 2);
                  if (pulse_done) begin
                     tick_cnt <= 32'd0;
                     if (step_cnt == {1'b0, led_pulse_count} - 9'h001) begin
                        step_cnt <= 9'h000;
                        state    <= ST_INTEG;
                     end else begin
                        step_cnt <= step_cnt + 9'h001;
                     end
                  end else begin
                     tick_cnt <= tick_cnt + 32'd1;
                  end
               end

               ST_INTEG: begin
                  // Integrate for (256 - time) steps
                  led_driver_pin_out <= 1'b0;
                  if (step_done) begin
                     tick_cnt <= 32'd0;
                     if (step_cnt == `STEP_COUNT_SPAN -
                                     {1'b0, integration_time} - 9'h001) begin
                        step_cnt <= 9'h000;
                        state    <= ST_EVAL;
                     end else begin
                        step_cnt <= step_cnt + 9'h001;
                     end
                  end else begin
                     tick_cnt <= tick_cnt + 32'd1;
                  end
               end

               ST_EVAL: begin
                  // Track persistence and move on
                  // Result must be steady here
                  out_run     <= next_out_run;
                  tick_cnt    <= 32'd0;
                  step_cnt    <= 9'h000;
                  stretch_cnt <= 4'h0;
                  state       <= wait_enable ? ST_WAIT : ST_IDLE;
               end

               ST_WAIT: begin
                  // (256 - wait) steps, each stretched if asked
                  // Cleared wait bit ends it at once
                  if (!wait_enable) begin
                     state <= ST_IDLE;
                  end else if (step_done) begin
                     tick_cnt <= 32'd0;
                     if (wait_stretch && stretch_cnt != STRETCH - 1) begin
                        stretch_cnt <= stretch_cnt + 4'h1;
                     end else begin
                        stretch_cnt <= 4'h0;
                        if (step_cnt == `STEP_COUNT_SPAN -
                                        {1'b0, wait_duration} - 9'h001)
                           state <= ST_IDLE;
                        else
                           step_cnt <= step_cnt + 9'h001;
                     end
                  end else begin
                     tick_cnt <= tick_cnt + 32'd1;
                  end
               end

               default: state <= ST_IDLE;
            endcase
         end
      end
   end

endmodule
